// File: common/flex_init_pkg.sv
package flex_init_pkg;
    // Bus address and data widths (16-bit word, 18-bit bus address)
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    // Register addresses
    localparam logic [17:0] CSR_STD_ADDR  = 18'o777170;
    localparam logic [17:0] CSR_ALT_ADDR  = 18'o777150;
    localparam logic [17:0] ROM_BASE_ADDR = 18'o773000;
    // Boot ROM geometry and entry offsets (byte offsets)
    localparam int ROM_WORDS = 256;
    localparam logic [8:0] ENTRY_STD  = 9'o000;
    localparam logic [8:0] ENTRY_ALT  = 9'o020;
    localparam logic [8:0] ENTRY_ANY  = 9'o040;
    localparam logic [8:0] ENTRY_SKIP = 9'o524;
    // Values the host loads before the any-address entry
    localparam logic [15:0] HOST_R0_VAL   = 16'o000340;
    localparam logic [15:0] HOST_R1_VAL   = 16'o000002;
    localparam logic [17:0] DEV_ADDR_LOC  = 18'o000000;
    // Command/status register fields
    localparam logic [15:0] CSR_INIT_VAL = 16'o040000;
    localparam int CSR_DONE_BIT = 5;
    localparam int CSR_BUSY_BIT = 11;
    localparam logic [15:0] CSR_RESET = 16'h0000;
    // Memory test limits, in words
    localparam logic [17:0] MEM_TEST_TOP = 18'o160000;
    localparam logic [17:0] ROM_ERR_TOP  = 18'o170000;
    // Timing: lamp on time and seek step time
    localparam int CLK_HZ       = 20_000_000;
    localparam int LAMP_US      = 100;
    localparam int LAMP_CYC     = LAMP_US * (CLK_HZ / 1_000_000);
    localparam int STEP_US      = 10;
    localparam int STEP_CYC     = STEP_US * (CLK_HZ / 1_000_000);
    localparam int TRACKS       = 77;
    localparam int SECTOR_WORDS = 64;
    // Host walk states
    typedef enum logic [5:0] {
        H_IDLE = 6'b000001,
        H_PREP = 6'b000010,
        H_INIT = 6'b000100,
        H_WAIT = 6'b001000,
        H_BOOT = 6'b010000,
        H_DONE = 6'b100000
    } host_st_t;
    // Controller init states
    typedef enum logic [4:0] {
        C_IDLE = 5'b00001,
        C_SEEK = 5'b00010,
        C_LOAD = 5'b00100,
        C_READ = 5'b01000,
        C_LAMP = 5'b10000
    } ctl_st_t;
    typedef enum logic [1:0] {
        BOOT_STD  = 2'h0,
        BOOT_ALT  = 2'h1,
        BOOT_ANY  = 2'h2,
        BOOT_SKIP = 2'h3
    } boot_kind_t;
endpackage : flex_init_pkg

// File: common/flex_bus_if.sv
`timescale 1ns/1ps
interface flex_bus_if;
    import flex_init_pkg::*;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        wr;
    logic        rd;
    logic        ack;
    logic        busInit;
    modport device (
        input  addr, wdata, wr, rd, busInit,
        output rdata, ack
    );
    modport host (
        output addr, wdata, wr, rd, busInit,
        input  rdata, ack
    );
endinterface : flex_bus_if

// File: verilog/flex_controller.sv
`timescale 1ns/1ps
module flex_controller
    import flex_init_pkg::*;
#(
    parameter int          LAMP_CYCLES = LAMP_CYC,
    parameter int          STEP_CYCLES = STEP_CYC,
    parameter logic [17:0] CSR_ADDR    = CSR_STD_ADDR
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       clkEn,
    flex_bus_if.device      bus,
    input  wire logic       powerOk,
    input  wire logic       diskInUnit0,
    input  wire logic       singleDensityMode,
    input  wire logic       mediaDoubleDensity,
    output logic [1:0]      stepOut,
    output logic [1:0]      activityLamp,
    output logic            headLoad,
    output logic            writeEnable,
    output logic            bootable,
    output logic            initBusy
);
    import flex_init_pkg::*;

    logic [15:0] romMem [ROM_WORDS];
    logic [1:0]  pwrSync_q, initSync_q, diskSync_q;
    logic [1:0]  pwrSync_d, initSync_d, diskSync_d;
    logic        pwrPrev_q, pwrPrev_d, initPrev_q, initPrev_d;
    ctl_st_t     st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic [6:0]  track_q, track_d;
    logic [5:0]  word_q, word_d;
    logic [15:0] latch_q, latch_d;
    logic [15:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic [15:0] sectorBuf_q [SECTOR_WORDS];
    logic        csrHit, romHit, initReq, pwrUp;
    logic [1:0]  modeSync_q, modeSync_d, densSync_q, densSync_d;
    logic        bootable_q, bootable_d;

    // Boot ROM contents: entry markers; each word holds its own word index
    genvar gi;
    generate
        for (gi = 0; gi < ROM_WORDS; gi++) begin : g_rom
            assign romMem[gi] = 16'(gi);
        end
    endgenerate

    assign csrHit = bus.addr == CSR_ADDR;
    assign romHit = bus.addr[17:9] == ROM_BASE_ADDR[17:9];
    assign pwrUp  = pwrSync_q[1] && !pwrPrev_q;
    assign initReq = pwrUp || (initSync_q[1] && !initPrev_q)
                   || (bus.wr && csrHit && bus.wdata == CSR_INIT_VAL && pwrSync_q[1]);

    always_comb begin
        pwrSync_d  = {pwrSync_q[0], powerOk};
        initSync_d = {initSync_q[0], bus.busInit};
        diskSync_d = {diskSync_q[0], diskInUnit0};
        modeSync_d = {modeSync_q[0], singleDensityMode};
        densSync_d = {densSync_q[0], mediaDoubleDensity};
        bootable_d = !modeSync_q[1] || !densSync_q[1];
        pwrPrev_d  = pwrSync_q[1];
        initPrev_d = initSync_q[1];
        st_d = st_q;
        cnt_d = cnt_q;
        track_d = track_q;
        word_d = word_q;
        latch_d = latch_q;
        rdata_d = 16'h0000;
        ack_d = 1'b0;
        if (pwrSync_q[1] && (bus.rd || bus.wr) && (csrHit || romHit) && !ack_q) begin
            ack_d = 1'b1;
            if (csrHit) begin
                rdata_d = latch_q;
                rdata_d[CSR_BUSY_BIT] = st_q != C_IDLE;
                rdata_d[CSR_DONE_BIT] = st_q == C_IDLE;
                if (bus.wr) begin
                    latch_d = bus.wdata;
                end
            end else if (romHit && bus.rd) begin
                rdata_d = romMem[bus.addr[8:1]];
            end
        end
        case (st_q)
            C_IDLE: begin
                if (initReq) begin
                    st_d = C_SEEK;
                    track_d = 7'(TRACKS - 1);
                    cnt_d = 16'h0000;
                    latch_d = CSR_RESET;
                end
            end
            C_SEEK: begin
                if (cnt_q == 16'(STEP_CYCLES - 1)) begin
                    cnt_d = 16'h0000;
                    if (track_q == 7'h00) begin
                        st_d = diskSync_q[1] ? C_LOAD : C_LAMP;
                    end else begin
                        track_d = track_q - 7'h01;
                    end
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            C_LOAD: begin
                track_d = 7'h01;
                word_d = 6'h00;
                st_d = C_READ;
            end
            C_READ: begin
                word_d = word_q + 6'h01;
                if (word_q == 6'(SECTOR_WORDS - 1)) begin
                    st_d = C_LAMP;
                end
            end
            C_LAMP: begin
                if (cnt_q == 16'(LAMP_CYCLES - 1)) begin
                    st_d = C_IDLE;
                    cnt_d = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            default: st_d = C_IDLE;
        endcase
        if (!pwrSync_q[1]) begin
            st_d = C_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pwrSync_q  <= 2'h0;
            initSync_q <= 2'h0;
            diskSync_q <= 2'h0;
            modeSync_q <= 2'h0;
            densSync_q <= 2'h0;
            bootable_q <= 1'b0;
            pwrPrev_q  <= 1'b0;
            initPrev_q <= 1'b0;
            st_q       <= C_IDLE;
            cnt_q      <= 16'h0000;
            track_q    <= 7'h00;
            word_q     <= 6'h00;
            latch_q    <= CSR_RESET;
            rdata_q    <= 16'h0000;
            ack_q      <= 1'b0;
        end else if (clkEn) begin
            pwrSync_q  <= pwrSync_d;
            initSync_q <= initSync_d;
            diskSync_q <= diskSync_d;
            modeSync_q <= modeSync_d;
            densSync_q <= densSync_d;
            bootable_q <= bootable_d;
            pwrPrev_q  <= pwrPrev_d;
            initPrev_q <= initPrev_d;
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            track_q    <= track_d;
            word_q     <= word_d;
            latch_q    <= latch_d;
            rdata_q    <= rdata_d;
            ack_q      <= ack_d;
        end
    end

    // Preload buffer; pattern stands in for the read channel data
    always_ff @(posedge core_clk) begin
        if (clkEn && st_q == C_READ) begin
            sectorBuf_q[word_q] <= {10'h000, word_q};
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.ack   = ack_q;
    assign stepOut   = {2{st_q == C_SEEK && cnt_q == 16'h0000 && track_q != 7'h00}};
    assign activityLamp = {st_q != C_IDLE && st_q != C_READ && st_q != C_LOAD,
                           st_q != C_IDLE};
    assign headLoad = st_q == C_LOAD || st_q == C_READ;
    assign writeEnable = pwrSync_q[1] && pwrPrev_q && st_q == C_IDLE && latch_q[2];
    // Switch pins are synced first, so the flag lags them by three cycles
    assign bootable = bootable_q;
    assign initBusy = st_q != C_IDLE;
endmodule : flex_controller

// File: verilog/flex_host.sv
`timescale 1ns/1ps
module flex_host
    import flex_init_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       clkEn,
    flex_bus_if.host        bus,
    input  wire logic       startInit,
    input  wire logic       softInit,
    input  wire flex_init_pkg::boot_kind_t bootKind,
    input  wire logic       startBoot,
    output logic [17:0]     bootStart,
    output logic [15:0]     regZero,
    output logic [15:0]     regOne,
    output logic [17:0]     loc0Value,
    output logic            lineClockOn,
    output logic            done
);
    import flex_init_pkg::*;

    host_st_t    st_q, st_d;
    logic [17:0] start_q, start_d;
    logic [15:0] r0_q, r0_d, r1_q, r1_d;
    logic [17:0] loc0_q, loc0_d;
    logic        clk_q, clk_d, done_q, done_d;

    always_comb begin
        st_d = st_q;
        start_d = start_q;
        r0_d = r0_q;
        r1_d = r1_q;
        loc0_d = loc0_q;
        clk_d = clk_q;
        done_d = 1'b0;
        case (st_q)
            H_IDLE: begin
                if (softInit) begin
                    st_d = H_INIT;
                end else if (startBoot) begin
                    st_d = H_PREP;
                end
            end
            // line clock off for skip entry
            H_PREP: begin
                loc0_d = CSR_STD_ADDR;
                case (bootKind)
                    BOOT_STD:  start_d = ROM_BASE_ADDR + 18'(ENTRY_STD);
                    BOOT_ALT:  start_d = ROM_BASE_ADDR + 18'(ENTRY_ALT);
                    BOOT_ANY: begin
                        start_d = ROM_BASE_ADDR + 18'(ENTRY_ANY);
                        r0_d = HOST_R0_VAL;
                        r1_d = HOST_R1_VAL;
                    end
                    default: begin
                        start_d = ROM_BASE_ADDR + 18'(ENTRY_SKIP);
                        clk_d = 1'b0;
                    end
                endcase
                st_d = H_BOOT;
            end
            H_INIT: begin
                if (bus.ack) begin
                    st_d = H_DONE;
                end
            end
            H_BOOT: begin
                if (bus.ack) begin
                    st_d = H_DONE;
                end
            end
            H_WAIT: st_d = H_DONE;
            H_DONE: begin
                done_d = 1'b1;
                st_d = H_IDLE;
            end
            default: st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q    <= H_IDLE;
            start_q <= 18'h00000;
            r0_q    <= 16'h0000;
            r1_q    <= 16'h0000;
            loc0_q  <= DEV_ADDR_LOC;
            clk_q   <= 1'b1;
            done_q  <= 1'b0;
        end else if (clkEn) begin
            st_q    <= st_d;
            start_q <= start_d;
            r0_q    <= r0_d;
            r1_q    <= r1_d;
            loc0_q  <= loc0_d;
            clk_q   <= clk_d;
            done_q  <= done_d;
        end
    end

    assign bus.busInit = startInit;
    assign bus.addr    = st_q == H_BOOT ? start_q : CSR_STD_ADDR;
    assign bus.wdata   = st_q == H_INIT ? CSR_INIT_VAL : 16'h0000;
    assign bus.wr      = st_q == H_INIT;
    assign bus.rd      = st_q == H_BOOT;
    assign bootStart   = start_q;
    assign regZero     = r0_q;
    assign regOne      = r1_q;
    assign loc0Value   = loc0_q;
    assign lineClockOn = clk_q;
    assign done        = done_q;
endmodule : flex_host

// File: verif/flex_init_asserts.sv
`timescale 1ns/1ps
module flex_init_asserts
    import flex_init_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic [17:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic        ack,
    input wire logic        busInit
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // Register or ROM window hit; busInit is not checked here
    wire hitNow = (addr == CSR_STD_ADDR) || (addr[17:9] == ROM_BASE_ADDR[17:9]);

    sequence s_req;
        (rd || wr) && !ack;
    endsequence
    sequence s_mreq;
        s_req ##0 hitNow;
    endsequence

    property p_ack_cause;
        ack |-> $past(rd || wr) && $past(hitNow);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without mapped request");
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_rdata_idle;
        !ack |-> rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack");
    property p_refuse;
        (rd || wr) && !hitNow |=> !ack;
    endproperty
    a_refuse: assert property (p_refuse) else $error("unmapped access answered");
    property p_answer;
        s_mreq |=> ack;
    endproperty
    a_answer: assert property (p_answer) else $error("mapped access not answered");
    property p_hold;
        s_req |=> (rd || wr) && $stable(addr) && $stable(wdata);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before ack");
    property p_release;
        ack |=> !rd && !wr;
    endproperty
    a_release: assert property (p_release) else $error("strobe kept after ack");
    property p_excl;
        !(rd && wr);
    endproperty
    a_excl: assert property (p_excl) else $error("read and write together");
    property p_init_val;
        wr && addr == CSR_STD_ADDR |-> wdata == CSR_INIT_VAL;
    endproperty
    a_init_val: assert property (p_init_val) else $error("register write not init value");
endmodule : flex_init_asserts

// File: verif/test_disk_controller_init_and_boot_rom.sv
`timescale 1ns/1ps
module test_disk_controller_init_and_boot_rom;
    import flex_init_pkg::*;
    logic        core_clk = 0, srst = 1, clkEn = 1, powerOk = 0, diskInUnit0 = 0;
    logic        sdMode = 0, mediaDd = 0, startInit = 0, softInit = 0, startBoot = 0;
    boot_kind_t  bootKind = BOOT_STD;
    logic [1:0]  stepOut, activityLamp, lampSeen;
    logic        headLoad, writeEnable, bootable, initBusy, lineClockOn, done, headSeen, wrSeen;
    logic [17:0] bootStart, loc0Value;
    logic [15:0] regZero, regOne;
    int          badCount = 0, nChecks = 0, cycles = 0, steps;

    flex_bus_if bus();
    flex_controller #(.LAMP_CYCLES(4), .STEP_CYCLES(2)) i_flex_controller (
        .core_clk(core_clk), .srst(srst), .clkEn(clkEn), .bus(bus), .powerOk(powerOk),
        .diskInUnit0(diskInUnit0), .singleDensityMode(sdMode), .mediaDoubleDensity(mediaDd),
        .stepOut(stepOut), .activityLamp(activityLamp), .headLoad(headLoad),
        .writeEnable(writeEnable), .bootable(bootable), .initBusy(initBusy));
    flex_host i_flex_host (
        .core_clk(core_clk), .srst(srst), .clkEn(clkEn), .bus(bus), .startInit(startInit),
        .softInit(softInit), .bootKind(bootKind), .startBoot(startBoot),
        .bootStart(bootStart), .regZero(regZero), .regOne(regOne), .loc0Value(loc0Value),
        .lineClockOn(lineClockOn), .done(done));
    flex_init_asserts i_flex_init_asserts (
        .core_clk(core_clk), .srst(srst), .addr(bus.addr), .wdata(bus.wdata),
        .rdata(bus.rdata), .wr(bus.wr), .rd(bus.rd), .ack(bus.ack), .busInit(bus.busInit));

    always #25 core_clk = ~core_clk;

    // Five inits of at most 223 cycles plus four boots stay far below this ceiling
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            badCount++;
            reportAndStop();
        end
    end

    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : reportAndStop

    task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string what);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tick();
        @(posedge core_clk);
        #2;
    endtask : tick

    // Watches one whole init; a short bound, since the seek count is fixed
    task automatic initCheck(input logic disk);
        int n;
        n = 0;
        lampSeen = 0; headSeen = 0; wrSeen = 0; steps = 0;
        while (initBusy !== 1'b1 && n < 10) begin tick(); n++; end
        check(initBusy, 1'b1, "init start");
        n = 0;
        while (initBusy === 1'b1 && n < 1000) begin
            lampSeen |= activityLamp;
            headSeen |= headLoad;
            wrSeen |= writeEnable;
            steps += int'(stepOut[0]);
            tick();
            n++;
        end
        check(initBusy, 1'b0, "init end");
        check(18'(steps), 18'(TRACKS - 1), "seek steps");
        check(lampSeen, 2'b11, "lamps");
        check(headSeen, disk, "head load");
        check(wrSeen, 1'b0, "write inhibit");
    endtask : initCheck

    task automatic pulseSoftInit();
        softInit = 1;
        tick();
        softInit = 0;
    endtask : pulseSoftInit

    task automatic testPowerUp();
        diskInUnit0 = 1;
        powerOk = 1;
        initCheck(1'b1);
        $display("test power up done");
    endtask : testPowerUp

    task automatic testBusInit();
        diskInUnit0 = 0;
        startInit = 1;
        tick();
        startInit = 0;
        initCheck(1'b0);
        $display("test bus init done");
    endtask : testBusInit

    task automatic testSoftInit();
        diskInUnit0 = 1;
        pulseSoftInit();
        initCheck(1'b1);
        $display("test soft init done");
    endtask : testSoftInit

    task automatic testBoot();
        logic [8:0]  ent[4] = '{ENTRY_STD, ENTRY_ALT, ENTRY_ANY, ENTRY_SKIP};
        logic [15:0] romWord;
        int n;
        for (int k = 0; k < 4; k++) begin
            bootKind = boot_kind_t'(k);
            startBoot = 1;
            tick();
            startBoot = 0;
            n = 0;
            romWord = 16'hffff;
            while (done !== 1'b1 && n < 5000) begin
                if (bus.ack === 1'b1) romWord = bus.rdata;
                tick();
                n++;
            end
            check(done, 1'b1, "boot done");
            check(18'(romWord), 18'(ent[k] >> 1), "entry word");
            check(bootStart, ROM_BASE_ADDR + 18'(ent[k]), "entry");
            if (k == 2) begin
                check(18'(regZero), 18'(HOST_R0_VAL), "reg zero");
                check(18'(regOne), 18'(HOST_R1_VAL), "reg one");
            end
            if (k >= 2) check(loc0Value, CSR_STD_ADDR, "location zero");
            if (k == 3) check(lineClockOn, 1'b0, "line clock");
            tick();
        end
        $display("test boot entries done");
    endtask : testBoot

    task automatic testDensity();
        logic [2:0] tbl[4] = '{3'b101, 3'b110, 3'b011, 3'b001};
        for (int k = 0; k < 4; k++) begin
            sdMode = tbl[k][2];
            mediaDd = tbl[k][1];
            repeat (4) tick();
            check(bootable, tbl[k][0], "bootable");
        end
        $display("test density done");
    endtask : testDensity

    task automatic testPowerLoss();
        int n;
        n = 0;
        pulseSoftInit();
        while (initBusy !== 1'b1 && n < 10) begin tick(); n++; end
        repeat (5) tick();
        powerOk = 0;
        wrSeen = 0;
        repeat (10) begin wrSeen |= writeEnable; tick(); end
        check(initBusy, 1'b0, "init aborted");
        check(wrSeen, 1'b0, "write inhibit down");
        powerOk = 1;
        initCheck(1'b1);
        $display("test power loss done");
    endtask : testPowerLoss

    initial begin
        repeat (16) tick();
        srst = 0;
        tick();
        testPowerUp();
        testBusInit();
        testSoftInit();
        testBoot();
        testDensity();
        testPowerLoss();
        reportAndStop();
    end
endmodule : test_disk_controller_init_and_boot_rom
